// ===== src/trig_seq.sv
/*
  Measurement trigger sequencer: initiate, control-event wait, delay,
  sample loop and measure count, with host registers on a strobe port.
  Assumes the measurement engine answers each o_sample_start with one
  i_sample_done pulse on the same clock; key and line inputs are async.
*/
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// - single initiate runs one cycle, then idle
// - continuous enable restarts cycle after each completion
// - measure count 1..110000 or endless infinity
// - programmed delay 0..999999.999 s after event
// - auto delay replaces programmed delay, default off
// - wait only for selected source, default immediate
// - timer source fires every 0.001..999999.999 s
// - signal request bypasses one control-event wait
// - sample count 1..110000 per accepted event
// - preset sets continuous, reset clears it
// - preset loads infinity, reset loads count one
// - every setting reads back as in effect
module trig_seq #(
  parameter int TICK      = trig_seq_pkg::TICK_CYCLES,
  parameter int AUTO_DLY  = trig_seq_pkg::AUTO_DELAY_MS
) (
  // clock and reset
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst,
  // register port
  input  wire trig_seq_pkg::bus_req_s i_bus,
  output logic [31:0]                 o_rdata,
  // external event pins
  input  wire logic                   i_manual_key,
  input  wire logic                   i_ext_trig,
  // measurement engine
  input  wire logic                   i_sample_done,
  output logic                        o_sample_start,
  output logic                        o_busy
);
  import trig_seq_pkg::*;

  localparam logic [16:0] TICK_LAST = 17'(TICK - 1);
  localparam logic [DLY_W-1:0] AUTO_MS = DLY_W'(AUTO_DLY);

  core_s q;
  core_s d;

  logic             ms_tick;
  logic             wr_cmd;
  logic             ext_edge;
  logic             man_edge;
  logic             event_ok;
  logic             tmr_fire;
  logic [CNT_W-1:0] wcnt;
  logic [DLY_W-1:0] wdly;
  logic [31:0]      rd_mux;

  always_comb begin
    d        = q;
    wcnt     = i_bus.wdata[CNT_W-1:0];
    wdly     = i_bus.wdata[DLY_W-1:0];
    wr_cmd   = i_bus.wr && (i_bus.addr == OFF_CMD);
    ms_tick  = (q.tick == TICK_LAST);
    ext_edge = q.ext_sync[1] && !q.ext_sync[2];
    man_edge = q.man_sync[1] && !q.man_sync[2];
    event_ok = 1'b0;
    tmr_fire = (q.src == SRC_TIMER) && ms_tick && (q.tmr_left <= TMR_MIN);
    rd_mux   = 32'h00000000;

    // pin synchronisers
    d.ext_sync = {q.ext_sync[1:0], i_ext_trig};
    d.man_sync = {q.man_sync[1:0], i_manual_key};

    // millisecond time base
    d.tick = ms_tick ? 17'h00000 : q.tick + 17'h00001;

    // interval timer, free running while selected
    if (q.src != SRC_TIMER) begin
      d.tmr_left = q.timer_ms;
      d.tmr_ev   = 1'b0;
    end else if (ms_tick) begin
      if (q.tmr_left <= TMR_MIN) begin
        d.tmr_left = q.timer_ms;
        d.tmr_ev   = 1'b1;
      end else begin
        d.tmr_left = q.tmr_left - TMR_MIN;
      end
    end

    // register writes
    if (i_bus.wr) begin
      case (i_bus.addr)
        OFF_CTRL: begin
          d.cont     = i_bus.wdata[CTRL_CONT];
          d.auto_dly = i_bus.wdata[CTRL_AUTO];
          if (i_bus.wdata[CTRL_SRC_LSB+:3] <= 3'(SRC_EXT)) begin
            d.src = src_e'(i_bus.wdata[CTRL_SRC_LSB+:3]);
          end
        end
        OFF_MEAS: begin
          d.meas_inf = i_bus.wdata[MEAS_INF_BIT];
          if (wcnt < CNT_MIN) begin
            d.meas_cnt = CNT_MIN;
          end else if (wcnt > CNT_MAX) begin
            d.meas_cnt = CNT_MAX;
          end else begin
            d.meas_cnt = wcnt;
          end
        end
        OFF_SAMP: begin
          if (wcnt < CNT_MIN) begin
            d.samp_cnt = CNT_MIN;
          end else if (wcnt > CNT_MAX) begin
            d.samp_cnt = CNT_MAX;
          end else begin
            d.samp_cnt = wcnt;
          end
        end
        OFF_DELAY: begin
          d.delay_ms = (wdly > DLY_MAX) ? DLY_MAX : wdly;
        end
        OFF_TIMER: begin
          if (wdly < TMR_MIN) begin
            d.timer_ms = TMR_MIN;
          end else if (wdly > DLY_MAX) begin
            d.timer_ms = DLY_MAX;
          end else begin
            d.timer_ms = wdly;
          end
        end
        default: begin
        end
      endcase
    end

    // pending one-shot requests; a new request wins over consumption
    if (wr_cmd && i_bus.wdata[CMD_SIGNAL]) begin
      d.sig_pend = 1'b1;
    end
    if (wr_cmd && i_bus.wdata[CMD_BUS_TRG]) begin
      d.bus_pend = 1'b1;
    end

    // selected control source only
    case (q.src)
      SRC_IMM:    event_ok = 1'b1;
      SRC_TIMER:  event_ok = q.tmr_ev;
      SRC_MANUAL: event_ok = man_edge;
      SRC_BUS:    event_ok = q.bus_pend;
      SRC_EXT:    event_ok = ext_edge;
      default:    event_ok = 1'b0;
    endcase

    // sequencer
    d.sample = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if ((wr_cmd && i_bus.wdata[CMD_INIT]) || q.cont) begin
          d.st     = ST_WAIT;
          d.remain = q.meas_cnt;
        end
      end
      ST_WAIT: begin
        if (event_ok || q.sig_pend) begin
          if (q.sig_pend && !(wr_cmd && i_bus.wdata[CMD_SIGNAL])) begin
            d.sig_pend = 1'b0;
          end
          if (q.src == SRC_BUS && q.bus_pend && !q.sig_pend &&
              !(wr_cmd && i_bus.wdata[CMD_BUS_TRG])) begin
            d.bus_pend = 1'b0;
          end
          if (q.src == SRC_TIMER && !q.sig_pend && !tmr_fire) begin
            d.tmr_ev = 1'b0;
          end
          d.dly_left  = q.auto_dly ? AUTO_MS : q.delay_ms;
          d.samp_left = q.samp_cnt;
          d.st        = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (q.dly_left == DLY_RST) begin
          d.st = ST_SAMP;
        end else if (ms_tick) begin
          d.dly_left = q.dly_left - TMR_MIN;
        end
      end
      ST_SAMP: begin
        d.sample    = 1'b1;
        d.samp_left = q.samp_left - CNT_MIN;
        d.st        = ST_DONE;
      end
      ST_DONE: begin
        if (i_sample_done) begin
          d.st = (q.samp_left == '0) ? ST_NEXT : ST_SAMP;
        end
      end
      ST_NEXT: begin
        if (q.meas_inf) begin
          d.st = ST_WAIT;
        end else if (q.remain <= CNT_MIN) begin
          d.st = ST_IDLE;
        end else begin
          d.remain = q.remain - CNT_MIN;
          d.st     = ST_WAIT;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // abort and the two reset commands
    if (wr_cmd && i_bus.wdata[CMD_ABORT]) begin
      d.st     = ST_IDLE;
      d.sample = 1'b0;
    end
    if (wr_cmd && i_bus.wdata[CMD_PRESET]) begin
      d.cont     = 1'b1;
      d.meas_inf = 1'b1;
      d.st       = ST_IDLE;
      d.sample   = 1'b0;
    end
    if (wr_cmd && i_bus.wdata[CMD_RST]) begin
      d.cont     = 1'b0;
      d.meas_inf = 1'b0;
      d.meas_cnt = CNT_MIN;
      d.st       = ST_IDLE;
      d.sample   = 1'b0;
    end

    // read back of settings in effect
    case (i_bus.addr)
      OFF_CTRL: begin
        rd_mux[CTRL_CONT]         = q.cont;
        rd_mux[CTRL_AUTO]         = q.auto_dly;
        rd_mux[CTRL_SRC_LSB+:3]   = q.src;
      end
      OFF_MEAS: begin
        rd_mux[CNT_W-1:0]   = q.meas_cnt;
        rd_mux[MEAS_INF_BIT] = q.meas_inf;
      end
      OFF_SAMP:  rd_mux[CNT_W-1:0] = q.samp_cnt;
      OFF_DELAY: rd_mux[DLY_W-1:0] = q.delay_ms;
      OFF_TIMER: rd_mux[DLY_W-1:0] = q.timer_ms;
      OFF_STATUS: begin
        rd_mux[CNT_W-1:0]         = q.remain;
        rd_mux[STAT_ST_LSB+:6]    = q.st;
      end
      default: rd_mux = 32'h00000000;
    endcase
    d.rdata = i_bus.rd ? rd_mux : 32'h00000000;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.src      <= SRC_IMM;
      q.meas_cnt <= CNT_MIN;
      q.samp_cnt <= CNT_MIN;
      q.delay_ms <= DLY_RST;
      q.timer_ms <= TMR_RST;
      q.tmr_left <= TMR_RST;
      q.remain   <= CNT_MIN;
    end else begin
      q <= d;
    end
  end

  assign o_rdata        = q.rdata;
  assign o_sample_start = q.sample;
  assign o_busy         = (q.st != ST_IDLE);

endmodule : trig_seq

// ===== src/trig_seq_pkg.sv
/*
  Shared constants and types for the measurement trigger sequencer.
  Assumes a 100 MHz core clock and a simple strobe-based register port.
*/
package trig_seq_pkg;

  // widths
  localparam int CNT_W  = 17;
  localparam int DLY_W  = 30;
  localparam int ADDR_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CMD    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MEAS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SAMP   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_DELAY  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_TIMER  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;

  // field positions
  localparam int CTRL_CONT    = 0;
  localparam int CTRL_AUTO    = 1;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CMD_INIT     = 0;
  localparam int CMD_ABORT    = 1;
  localparam int CMD_SIGNAL   = 2;
  localparam int CMD_BUS_TRG  = 3;
  localparam int CMD_PRESET   = 4;
  localparam int CMD_RST      = 5;
  localparam int MEAS_INF_BIT = 31;
  localparam int STAT_ST_LSB  = 24;

  // value limits and values after reset
  localparam logic [CNT_W-1:0] CNT_MIN   = 17'h00001;
  localparam logic [CNT_W-1:0] CNT_MAX   = 17'h1ADB0;
  localparam logic [DLY_W-1:0] DLY_MAX   = 30'h3B9AC9FF;
  localparam logic [DLY_W-1:0] DLY_RST   = 30'h00000000;
  localparam logic [DLY_W-1:0] TMR_MIN   = 30'h00000001;
  localparam logic [DLY_W-1:0] TMR_RST   = 30'h00000064;

  // time base: delay and timer count in milliseconds
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
  localparam int AUTO_DELAY_MS = 1;

  typedef enum logic [2:0] {
    SRC_IMM    = 3'h0,
    SRC_TIMER  = 3'h1,
    SRC_MANUAL = 3'h2,
    SRC_BUS    = 3'h3,
    SRC_EXT    = 3'h4
  } src_e;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_WAIT  = 6'h02,
    ST_DELAY = 6'h04,
    ST_SAMP  = 6'h08,
    ST_DONE  = 6'h10,
    ST_NEXT  = 6'h20
  } state_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } bus_req_s;

  typedef struct packed {
    state_e            st;
    logic              cont;
    logic              auto_dly;
    src_e              src;
    logic [CNT_W-1:0]  meas_cnt;
    logic              meas_inf;
    logic [CNT_W-1:0]  samp_cnt;
    logic [DLY_W-1:0]  delay_ms;
    logic [DLY_W-1:0]  timer_ms;
    logic [CNT_W-1:0]  remain;
    logic [CNT_W-1:0]  samp_left;
    logic [DLY_W-1:0]  dly_left;
    logic [DLY_W-1:0]  tmr_left;
    logic [16:0]       tick;
    logic              tmr_ev;
    logic              sig_pend;
    logic              bus_pend;
    logic [2:0]        ext_sync;
    logic [2:0]        man_sync;
    logic              sample;
    logic [31:0]       rdata;
  } core_s;

endpackage : trig_seq_pkg

// ===== tb/trig_seq_chk.sv
/*
  Port checker for the trigger sequencer.
  Assumes it is bound to every trig_seq instance.
*/
`timescale 1ns/1ps
module trig_seq_chk
  import trig_seq_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire bus_req_s    i_bus,
  input  wire logic [31:0] o_rdata,
  input  wire logic        o_sample_start,
  input  wire logic        o_busy
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // command write with one bit set
  sequence s_cmd(int b);
    i_bus.wr && i_bus.addr == OFF_CMD && i_bus.wdata[b];
  endsequence
  AST_RD_IDLE: assert property (!i_bus.rd |=> o_rdata == '0)
    else $error("read data not zero without read");
  AST_CMD_RD: assert property (i_bus.rd && i_bus.addr == OFF_CMD
    |=> o_rdata == '0) else $error("command reads nonzero");
  AST_START_PULSE: assert property (o_sample_start |=> !o_sample_start)
    else $error("sample start longer than one cycle");
  AST_START_BUSY: assert property (o_sample_start |-> o_busy)
    else $error("sample start while idle");
  AST_ROSE_WAIT: assert property ($rose(o_busy) |-> !o_sample_start)
    else $error("sample before event wait");
  AST_INIT: assert property (s_cmd(CMD_INIT) ##0 !o_busy |=> o_busy)
    else $error("initiate did not leave idle");
  AST_ABORT: assert property (s_cmd(CMD_ABORT) |=> !o_busy
    && !o_sample_start) else $error("abort did not stop");
  AST_STD_RST: assert property (s_cmd(CMD_RST) |=> !o_busy ##1 !o_busy)
    else $error("reset command left sequencer running");
endmodule : trig_seq_chk

bind trig_seq trig_seq_chk u_chk (.i_core_clk, .i_rst, .i_bus, .o_rdata,
  .o_sample_start, .o_busy);

// ===== tb/meas_engine_model.sv
/*
  Measurement engine stand-in: one done pulse per sample start.
  Assumes start is a one-cycle pulse; latency 0..3 extra cycles.
*/
`timescale 1ns/1ps
module meas_engine_model (
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  // sequencer side
  input  wire logic       i_start,
  input  wire logic [1:0] i_lat,
  output logic            o_done
);
  int left;
  always @(posedge i_core_clk) begin
    if (i_rst || (i_start && i_lat == 2'h0)) left <= 0;
    else if (i_start) left <= int'(i_lat);
    else if (left > 0) left <= left - 1;
    o_done <= !i_rst && ((i_start && i_lat == 2'h0) || left == 1);
  end
endmodule : meas_engine_model

// ===== tb/trig_seq_tb.sv
/*
  Self-checking bench for the trigger sequencer.
  Assumes a ten-cycle millisecond tick in simulation.
*/
`timescale 1ns/1ps
module trig_seq_tb;
  import trig_seq_pkg::*;
  logic i_core_clk, i_rst, i_manual_key, i_ext_trig, i_sample_done;
  logic o_sample_start, o_busy;
  logic [31:0] o_rdata, m_ctrl, m_meas, m_samp, m_dly, m_tmr;
  logic [1:0] lat;
  bus_req_s i_bus;
  int err_count, comparisons, starts, cyc, s0, n;

  trig_seq #(.TICK(10), .AUTO_DLY(1)) dut (.i_core_clk, .i_rst, .i_bus,
    .o_rdata, .i_manual_key, .i_ext_trig, .i_sample_done,
    .o_sample_start, .o_busy);
  meas_engine_model eng (.i_core_clk, .i_rst, .i_start(o_sample_start),
    .i_lat(lat), .o_done(i_sample_done));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (o_sample_start === 1'b1) starts <= starts + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [16:0] cl(logic [16:0] v);
    return (v < CNT_MIN) ? CNT_MIN : (v > CNT_MAX) ? CNT_MAX : v;
  endfunction : cl
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_core_clk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_core_clk);
    i_bus <= '0;
    case (a)
      OFF_CTRL: m_ctrl = {25'h0, d[6:4] > 3'h4 ? m_ctrl[6:4] : d[6:4],
                          2'h0, d[1:0]};
      OFF_MEAS: m_meas = {d[31], 14'h0, cl(d[16:0])};
      OFF_SAMP: m_samp = {15'h0, cl(d[16:0])};
      OFF_DELAY: m_dly = 32'(d[29:0] > DLY_MAX ? DLY_MAX : d[29:0]);
      OFF_TIMER: m_tmr = 32'(d[29:0] > DLY_MAX ? DLY_MAX
                       : d[29:0] < TMR_MIN ? TMR_MIN : d[29:0]);
      OFF_CMD: begin
        if (d[CMD_PRESET]) {m_ctrl[0], m_meas[31]} = 2'b11;
        if (d[CMD_RST]) {m_ctrl[0], m_meas} = {1'b0, 32'h1};
      end
      default: ;
    endcase
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    @(posedge i_core_clk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge i_core_clk);
    i_bus <= '0;
    #1 chk(o_rdata, exp);
  endtask : rd
  task automatic rd_all();
    rd(OFF_CTRL, m_ctrl);
    rd(OFF_MEAS, m_meas);
    rd(OFF_SAMP, m_samp);
    rd(OFF_DELAY, m_dly);
    rd(OFF_TIMER, m_tmr);
    rd(OFF_STATUS, 32'h01000001);
    rd(OFF_CMD, 32'h0);
    rd(8'hFC, 32'h0);
  endtask : rd_all
  task automatic idle_wait();
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1 n++;
    end while (o_busy !== 1'b0 && n < 3000);
    chk(o_busy, 1'b0);
  endtask : idle_wait
  task automatic start_wait();
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1 n++;
    end while (o_sample_start !== 1'b1 && n < 500);
  endtask : start_wait
  task automatic init();
    s0 = starts;
    lat <= 2'($urandom_range(3));
    wr(OFF_CMD, 32'h1 << CMD_INIT);
  endtask : init
  task automatic pulse_lines();
    {i_manual_key, i_ext_trig} <= 2'b11;
    repeat (3) @(posedge i_core_clk);
    {i_manual_key, i_ext_trig} <= 2'b00;
  endtask : pulse_lines
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  initial begin
    {i_manual_key, i_ext_trig, lat, cyc, starts} = '0;
    i_rst = 1'b1;
    {err_count, comparisons} = '0;
    i_bus = '0;
    {m_ctrl, m_meas, m_samp} = {32'h0, 32'h1, 32'h1};
    m_dly = 32'(DLY_RST);
    m_tmr = 32'(TMR_RST);
    void'($urandom(7));
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd_all();
    wr(OFF_MEAS, 32'h0);
    wr(OFF_SAMP, 32'h1FFFF);
    wr(OFF_TIMER, 32'h0);
    wr(OFF_DELAY, 32'h3FFFFFFF);
    wr(OFF_CTRL, 32'h70);
    rd_all();
    repeat (3) begin
      wr(OFF_MEAS, $urandom_range(110000, 1));
      wr(OFF_SAMP, $urandom_range(110000, 1));
      wr(OFF_DELAY, $urandom_range(999999999));
      wr(OFF_TIMER, $urandom_range(999999999, 1));
      rd_all();
    end
    $display("test registers done");
    wr(OFF_DELAY, 32'h0);
    wr(OFF_MEAS, 32'h3);
    wr(OFF_SAMP, 32'h2);
    init();
    idle_wait();
    chk(starts - s0, 32'h6);
    $display("test single cycle done");
    wr(OFF_MEAS, 32'h1);
    wr(OFF_SAMP, 32'h1);
    wr(OFF_TIMER, 32'h1);
    for (int s = 1; s <= 4; s++) begin
      wr(OFF_CTRL, s << CTRL_SRC_LSB);
      rd(OFF_CTRL, m_ctrl);
      init();
      if (s == 3) pulse_lines();
      repeat (30) @(posedge i_core_clk);
      #1 chk(starts - s0, s == 1);
      if (s == 3) wr(OFF_CMD, 32'h1 << CMD_BUS_TRG);
      else if (s != 1) pulse_lines();
      idle_wait();
      chk(starts - s0, 32'h1);
    end
    wr(OFF_CTRL, 32'h3 << CTRL_SRC_LSB);
    init();
    repeat (20) @(posedge i_core_clk);
    wr(OFF_CMD, 32'h1 << CMD_SIGNAL);
    idle_wait();
    chk(starts - s0, 32'h1);
    $display("test sources done");
    wr(OFF_CTRL, 32'h0);
    wr(OFF_DELAY, 32'h2);
    init();
    start_wait();
    chk(n >= 10 && n <= 30, 32'h1);
    idle_wait();
    wr(OFF_CTRL, 32'h1 << CTRL_AUTO);
    wr(OFF_DELAY, 32'h5);
    init();
    start_wait();
    chk(n <= 16, 32'h1);
    idle_wait();
    $display("test delay done");
    wr(OFF_DELAY, 32'h0);
    wr(OFF_CTRL, 32'h1);
    init();
    repeat (60) @(posedge i_core_clk);
    #1 chk(starts - s0 > 3, 32'h1);
    wr(OFF_CMD, 32'h1 << CMD_RST);
    repeat (3) @(posedge i_core_clk);
    #1 chk(o_busy, 1'b0);
    rd_all();
    wr(OFF_DELAY, 32'h5);
    init();
    repeat (5) @(posedge i_core_clk);
    s0 = starts;
    wr(OFF_CMD, 32'h1 << CMD_ABORT);
    repeat (80) @(posedge i_core_clk);
    #1 chk(starts - s0, 32'h0);
    chk(o_busy, 1'b0);
    wr(OFF_CMD, 32'h1 << CMD_PRESET);
    repeat (200) @(posedge i_core_clk);
    #1 chk(o_busy, 1'b1);
    rd(OFF_CTRL, m_ctrl);
    rd(OFF_MEAS, m_meas);
    wr(OFF_CMD, 32'h1 << CMD_RST);
    $display("test commands done");
    print_verdict();
  end
endmodule : trig_seq_tb
